// >>> rtl/ubs_pkg.sv
// Package for the serial port break / synchronous master transmit block.
// Assumes one 20 MHz system clock and an APB register slave with 32-bit data.
package ubs_pkg;

	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_TXD = 8'h08;
	localparam logic [7:0] ADDR_RXD = 8'h0C;
	localparam logic [7:0] ADDR_BAUD = 8'h10;

	// Reset values
	localparam logic [11:0] CTRL_RST = 12'h000;
	localparam logic [15:0] BAUD_RST = 16'h0010;

	// Frame shapes, least significant bit leaves first
	localparam logic [13:0] IDLE_FRAME = 14'h3FFF;
	localparam logic [13:0] BREAK_FRAME = 14'h2000;
	localparam logic [3:0] BREAK_BITS = 4'hE;
	localparam logic [3:0] ASYNC_BITS8 = 4'hA;
	localparam logic [3:0] ASYNC_BITS9 = 4'hB;
	localparam logic [3:0] SYNC_BITS8 = 4'h8;
	localparam logic [3:0] SYNC_BITS9 = 4'h9;
	localparam logic [3:0] LAST_BIT = 4'h1;

	// Receive sample slots in whole bit periods after the start edge, each sampled mid-bit
	localparam logic [3:0] RX_START_IDX = 4'h0;
	localparam logic [3:0] RX_STOP_IDX = 4'h9;

	// Control register, bit 0 is transmit_enable
	typedef struct packed {
		logic autobaud_enable;
		logic wake_on_break_enable;
		logic ninth_transmit_bit;
		logic nine_bit_transmit;
		logic clock_polarity_select;
		logic port_enable;
		logic continuous_receive_enable;
		logic single_receive_enable;
		logic clock_source_master;
		logic serial_mode_clocked;
		logic send_break;
		logic transmit_enable;
	} ubs_ctrl_t;

	// Status register, bit 0 is shift_reg_empty
	typedef struct packed {
		logic break_seen;
		logic receive_idle;
		logic framing_error;
		logic receive_flag;
		logic transmit_buffer_flag;
		logic shift_reg_empty;
	} ubs_stat_t;

	typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} ubs_tx_state_t;
	typedef enum logic {RX_IDLE, RX_RUN} ubs_rx_state_t;

endpackage

// >>> rtl/ubs_top.sv
// Serial port transmit core: break generation, wake on break, async receive
// and synchronous master transmit, with an APB register slave.
// Assumes pins pass through pads resolved by the bench from the enables.
//
// Contract
// - A wake-up event while wake on break is enabled sets the receive flag.
// - Hardware clears wake on break at the rising data edge ending the break.
// - Reading receive data clears the wake-up receive flag; data is meaningless.
// - Break is one start bit, twelve zero bits, one stop bit.
// - With send break and transmit enable, a data write starts a break of zeros.
// - Send break self-clears after the break stop bit; queued byte follows.
// - Shift register empty shows activity during a break as for characters.
// - Transmit buffer flag sets when the holding register empties.
// - Break received shows as receive flag, framing error and zero byte.
// - After wake, two transitions pass then the next byte is received.
// - Synchronous mode sends no start or stop bits, half duplex.
// - Mode bits select synchronous, master, transmit direction and port enable.
// - Master drives the clock pin, exactly one clock per data bit.
// - Data changes on the leading clock edge, stable through the trailing edge.
// - Polarity set idles clock high; clear idles low.
// - Synchronous master transmit drives both data and clock pins.
// - A data write moves to the shift register at once if it is empty.
// - Nine-bit mode sends the ninth bit captured before the data write.
// - Wake on break suspends reception; a falling data edge is the wake event.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ubs_top
	import ubs_pkg::*;
(
	input wire logic clock_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic clock_pin_i,
	output logic clock_pin_o,
	output logic clock_pin_oe_n_o,
	input wire logic data_pin_i,
	output logic data_pin_o,
	output logic data_pin_oe_n_o
);

	ubs_ctrl_t ctrl_ff, nxt_ctrl;
	ubs_stat_t stat;
	ubs_tx_state_t tx_state_ff, nxt_tx_state;
	ubs_rx_state_t rx_state_ff;
	logic [15:0] baud_ff, div_ff, rx_div_ff;
	logic [7:0] thr_ff, rx_sh_ff, rx_data_ff;
	logic thr9_ff, thr_full_ff, thr_brk_ff;
	logic [13:0] shift_ff, nxt_shift;
	logic [3:0] tx_left_ff, nxt_left;
	logic tx_phase_ff, tx_brk_ff, sck_act_ff, sdat_ff;
	logic rx_meta_ff, rx_sync_ff, rx_prev_ff, wake_low_ff;
	logic [4:0] rx_half_ff;
	logic frame_err_ff, rcv_flag_ff;
	logic [31:0] prdata_ff;
	logic ck_o_ff, ck_oe_n_ff, dt_o_ff, dt_oe_n_ff;

	// Frame of an asynchronous character, stop bit and idle ones above it
	function automatic logic [13:0] async_frame(input logic [7:0] d, input logic nine,
		input logic b9);
		async_frame = {4'hF, nine ? b9 : 1'b1, d, 1'b0};
	endfunction

	function automatic logic [3:0] frame_bits(input logic sync, input logic nine);
		if (sync) begin
			frame_bits = nine ? SYNC_BITS9 : SYNC_BITS8;
		end else begin
			frame_bits = nine ? ASYNC_BITS9 : ASYNC_BITS8;
		end
	endfunction

	// Bus decode
	wire apb_setup = psel_i & ~penable_i;
	wire apb_acc = psel_i & penable_i;
	wire hit_ctrl = paddr_i == ADDR_CTRL;
	wire hit_stat = paddr_i == ADDR_STAT;
	wire hit_txd = paddr_i == ADDR_TXD;
	wire hit_rxd = paddr_i == ADDR_RXD;
	wire hit_baud = paddr_i == ADDR_BAUD;
	wire mapped = hit_ctrl | hit_stat | hit_txd | hit_rxd | hit_baud;
	wire wr_ctrl = apb_acc & pwrite_i & hit_ctrl;
	wire wr_txd = apb_acc & pwrite_i & hit_txd;
	wire wr_baud = apb_acc & pwrite_i & hit_baud;
	wire rd_rxd = apb_acc & ~pwrite_i & hit_rxd;

	assign pready_o = 1'b1;
	assign pslverr_o = apb_acc & ~mapped;

	// Mode decode
	wire mode_sync = ctrl_ff.serial_mode_clocked;
	wire mode_master = ctrl_ff.clock_source_master;
	wire rx_off = ~ctrl_ff.single_receive_enable & ~ctrl_ff.continuous_receive_enable;
	wire port_en = ctrl_ff.port_enable;
	// Slave mode has no engine here, so a slave setup never starts shifting
	wire tx_go = port_en & ctrl_ff.transmit_enable & (~mode_sync | (mode_master & rx_off));
	wire wake_arm = ctrl_ff.wake_on_break_enable;

	// Transmit side
	wire tx_idle = tx_state_ff == TX_IDLE;
	wire half_tick = div_ff == baud_ff;
	wire brk_pending = (thr_full_ff & thr_brk_ff) | (~tx_idle & tx_brk_ff);
	// Only the first write after send_break is a break, so the sync byte queues
	wire mark_brk = ctrl_ff.send_break & ctrl_ff.transmit_enable & ~mode_sync & ~brk_pending;
	wire tx_load = thr_full_ff & tx_go & tx_idle;
	wire bit_end = ~tx_idle & half_tick & tx_phase_ff;
	wire tx_last = bit_end & (tx_left_ff == LAST_BIT);
	wire brk_done = tx_last & tx_brk_ff;
	wire lead_edge = (tx_state_ff == TX_SYNC) & half_tick & ~tx_phase_ff;

	// Receive side
	wire rx_fall = rx_prev_ff & ~rx_sync_ff;
	wire rx_rise = ~rx_prev_ff & rx_sync_ff;
	wire rx_en = port_en & ~mode_sync & ctrl_ff.continuous_receive_enable & ~wake_arm;
	wire rx_run = rx_state_ff == RX_RUN;
	wire rx_tick = rx_div_ff == baud_ff;
	wire [4:0] rx_half_nxt = rx_half_ff + 5'h01;
	wire [3:0] rx_idx = rx_half_nxt[4:1];
	wire rx_sample = rx_run & rx_tick & rx_half_nxt[0];
	wire rx_abort = rx_sample & (rx_idx == RX_START_IDX) & rx_sync_ff;
	wire rx_done = rx_sample & (rx_idx == RX_STOP_IDX);
	wire wake_event = wake_arm & rx_fall & ~wake_low_ff;
	wire wake_end = wake_arm & wake_low_ff & rx_rise;
	wire flag_set = wake_event | rx_done;

	assign stat.shift_reg_empty = tx_idle;
	assign stat.transmit_buffer_flag = ~thr_full_ff;
	assign stat.receive_flag = rcv_flag_ff;
	assign stat.framing_error = frame_err_ff;
	assign stat.receive_idle = ~rx_run & ~wake_low_ff;
	assign stat.break_seen = rcv_flag_ff & frame_err_ff & (rx_data_ff == 8'h00);

	// Hardware clears lose to a software write of the same cycle
	always_comb begin
		nxt_ctrl = wr_ctrl ? ubs_ctrl_t'(pwdata_i[11:0]) : ctrl_ff;
		if (!wr_ctrl && brk_done) begin
			nxt_ctrl.send_break = 1'b0;
		end
		if (!wr_ctrl && wake_end) begin
			nxt_ctrl.wake_on_break_enable = 1'b0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ctrl_ff <= ubs_ctrl_t'(CTRL_RST);
			baud_ff <= BAUD_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wr_baud) begin
				baud_ff <= pwdata_i[15:0];
			end
		end
	end

	// Read data is captured in the setup phase, so it comes from a flip-flop
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			prdata_ff <= 32'h0000_0000;
		end else if (apb_setup && !pwrite_i) begin
			prdata_ff <= hit_ctrl ? {20'h0_0000, ctrl_ff} :
				hit_stat ? {26'h000_0000, stat} :
				hit_rxd ? {24'h00_0000, rx_data_ff} :
				hit_baud ? {16'h0000, baud_ff} : 32'h0000_0000;
		end
	end
	assign prdata_o = prdata_ff;

	// Holding register; the ninth bit is captured with the low byte
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			thr_ff <= 8'h00;
			thr9_ff <= 1'b0;
			thr_full_ff <= 1'b0;
			thr_brk_ff <= 1'b0;
		end else if (wr_txd) begin
			thr_ff <= pwdata_i[7:0];
			thr9_ff <= ctrl_ff.ninth_transmit_bit;
			thr_full_ff <= 1'b1;
			thr_brk_ff <= mark_brk;
		end else if (tx_load) begin
			thr_full_ff <= 1'b0;
		end
	end

	// Half bit divider, held at zero while idle so a frame starts aligned
	always_ff @(posedge clock_i) begin
		if (sys_rst_i || tx_idle || half_tick) begin
			div_ff <= 16'h0000;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
	end

	always_comb begin
		nxt_tx_state = tx_state_ff;
		nxt_shift = shift_ff;
		nxt_left = tx_left_ff;
		if (!port_en) begin
			nxt_tx_state = TX_IDLE;
			nxt_shift = IDLE_FRAME;
		end else if (tx_load) begin
			nxt_tx_state = mode_sync ? TX_SYNC : TX_ASYNC;
			if (thr_brk_ff) begin
				nxt_shift = BREAK_FRAME;
				nxt_left = BREAK_BITS;
			end else if (mode_sync) begin
				// A stale ninth bit stays out of an eight-bit frame
				nxt_shift = {5'h00, thr9_ff & ctrl_ff.nine_bit_transmit, thr_ff};
				nxt_left = frame_bits(1'b1, ctrl_ff.nine_bit_transmit);
			end else begin
				nxt_shift = async_frame(thr_ff, ctrl_ff.nine_bit_transmit, thr9_ff);
				nxt_left = frame_bits(1'b0, ctrl_ff.nine_bit_transmit);
			end
		end else if (bit_end) begin
			nxt_shift = {1'b1, shift_ff[13:1]};
			nxt_left = tx_left_ff - 4'h1;
			if (tx_last) begin
				nxt_tx_state = TX_IDLE;
				nxt_shift = IDLE_FRAME;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			tx_state_ff <= TX_IDLE;
			shift_ff <= IDLE_FRAME;
			tx_left_ff <= 4'h0;
			tx_phase_ff <= 1'b0;
			tx_brk_ff <= 1'b0;
		end else begin
			tx_state_ff <= nxt_tx_state;
			shift_ff <= nxt_shift;
			tx_left_ff <= nxt_left;
			tx_phase_ff <= (tx_load || !port_en) ? 1'b0 : tx_phase_ff ^ (half_tick & ~tx_idle);
			if (tx_load) begin
				tx_brk_ff <= thr_brk_ff;
			end
		end
	end

	// Synchronous clock and data: data moves with the leading edge only
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			sck_act_ff <= 1'b0;
			sdat_ff <= 1'b1;
		end else if (!port_en || tx_state_ff != TX_SYNC) begin
			sck_act_ff <= 1'b0;
		end else if (half_tick) begin
			sck_act_ff <= ~tx_phase_ff;
			if (!tx_phase_ff) begin
				sdat_ff <= shift_ff[0];
			end
		end
	end

	// Pin drivers; both pins lag the engine by the same one cycle
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ck_o_ff <= 1'b1;
			ck_oe_n_ff <= 1'b1;
			dt_o_ff <= 1'b1;
			dt_oe_n_ff <= 1'b1;
		end else begin
			ck_o_ff <= mode_sync ? ctrl_ff.clock_polarity_select ^ sck_act_ff : shift_ff[0];
			ck_oe_n_ff <= ~(port_en & (mode_sync ? mode_master : ctrl_ff.transmit_enable));
			dt_o_ff <= sdat_ff;
			dt_oe_n_ff <= ~(port_en & mode_sync & mode_master & rx_off);
		end
	end
	assign clock_pin_o = ck_o_ff;
	assign clock_pin_oe_n_o = ck_oe_n_ff;
	assign data_pin_o = dt_o_ff;
	assign data_pin_oe_n_o = dt_oe_n_ff;

	// Data pin synchroniser and edge history
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_meta_ff <= data_pin_i;
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
		end
	end

	// Async receiver, sampling mid-bit; a short start glitch is dropped
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rx_state_ff <= RX_IDLE;
			rx_div_ff <= 16'h0000;
			rx_half_ff <= 5'h00;
			rx_sh_ff <= 8'h00;
			rx_data_ff <= 8'h00;
			frame_err_ff <= 1'b0;
		end else if (!rx_en) begin
			rx_state_ff <= RX_IDLE;
		end else if (!rx_run) begin
			rx_div_ff <= 16'h0000;
			rx_half_ff <= 5'h00;
			if (rx_fall) begin
				rx_state_ff <= RX_RUN;
			end
		end else begin
			rx_div_ff <= rx_tick ? 16'h0000 : rx_div_ff + 16'h0001;
			if (rx_tick) begin
				rx_half_ff <= rx_half_nxt;
			end
			if (rx_abort) begin
				rx_state_ff <= RX_IDLE;
			end else if (rx_done) begin
				rx_state_ff <= RX_IDLE;
				rx_data_ff <= rx_sh_ff;
				frame_err_ff <= ~rx_sync_ff;
			end else if (rx_sample && rx_idx != RX_START_IDX) begin
				rx_sh_ff <= {rx_sync_ff, rx_sh_ff[7:1]};
			end
		end
	end

	// Receive flag: a new event in the read cycle still sets it
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			rcv_flag_ff <= 1'b0;
			wake_low_ff <= 1'b0;
		end else begin
			rcv_flag_ff <= flag_set | (rcv_flag_ff & ~rd_rxd);
			if (!wake_arm || wake_end) begin
				wake_low_ff <= 1'b0;
			end else if (wake_event) begin
				wake_low_ff <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (sys_rst_i);

	a_wake_sets_flag: assert property (wake_event |=> rcv_flag_ff && wake_low_ff)
		else $error("wake event did not set the receive flag");
	a_wake_ends_wue: assert property (wake_end && !wr_ctrl |=> !ctrl_ff.wake_on_break_enable)
		else $error("wake enable not cleared at end of break");
	a_read_clears_flag: assert property (rd_rxd && !flag_set |=> !rcv_flag_ff)
		else $error("receive data read did not clear flag");
	a_rx_suspended: assert property (wake_arm |=> !rx_run)
		else $error("reception active during wake on break");
	a_break_frame: assert property (tx_load && thr_brk_ff |=>
		shift_ff == BREAK_FRAME && tx_left_ff == BREAK_BITS && !stat.shift_reg_empty)
		else $error("break frame not loaded");
	a_break_clears_sb: assert property (brk_done && !wr_ctrl |=> !ctrl_ff.send_break)
		else $error("send break not cleared after break stop bit");
	a_write_fills_buf: assert property (wr_txd |=> !stat.transmit_buffer_flag)
		else $error("transmit buffer flag still set after write");
	a_load_at_once: assert property (tx_go && tx_idle && wr_txd ##1 port_en |=> !tx_idle)
		else $error("byte not moved to shift register at once");
	a_sync_bits: assert property (tx_load && mode_sync && !ctrl_ff.nine_bit_transmit |=>
		tx_left_ff == SYNC_BITS8 && shift_ff[13:8] == 6'h00)
		else $error("synchronous frame length wrong");
	a_ninth_bit: assert property (tx_load && mode_sync && ctrl_ff.nine_bit_transmit |=>
		shift_ff[8] == $past(thr9_ff) && tx_left_ff == SYNC_BITS9)
		else $error("ninth bit not taken from capture");
	a_data_on_lead: assert property ((tx_state_ff == TX_SYNC) && !lead_edge |=> $stable(sdat_ff))
		else $error("data moved away from a leading edge");
	// The pin follows the polarity of the cycle before, so a polarity write is no failure
	a_clock_idle: assert property (!sck_act_ff && mode_sync |=>
		clock_pin_o == $past(ctrl_ff.clock_polarity_select))
		else $error("clock idle level wrong for polarity");
	a_pins_driven: assert property ((tx_state_ff == TX_SYNC) && $stable(ctrl_ff) |=>
		!data_pin_oe_n_o && !clock_pin_oe_n_o)
		else $error("pins not driven during synchronous transmit");

	c_break_sent: cover property (brk_done);
	c_wake_seen: cover property (wake_event ##[1:1000] wake_end);
	c_sync_char: cover property ((tx_state_ff == TX_SYNC) && tx_last);
	c_break_rx: cover property (rx_done ##1 stat.break_seen);

endmodule

`default_nettype wire

// >>> tb/tb_uart_break_sync_master_tx.sv
// Self-checking bench for the break and synchronous master transmit port.
// Assumes APB access, pulled-up pins and a bit of eight system clocks.
`timescale 1ns/1ns
`default_nettype none

module tb_uart_break_sync_master_tx import ubs_pkg::*;;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, ck_o, ck_oe_n, dt_o, dt_oe_n, drv_en, drv_val;
	logic [31:0] rd;
	logic er;
	logic [15:0] f1, f2;
	int mismatches = 0;
	int comparisons = 0;
	wire clock_wire = !ck_oe_n ? ck_o : 1'b1;
	wire data_wire = !dt_oe_n ? dt_o : (drv_en ? drv_val : 1'b1);

	initial begin
		forever #25 clock_i = ~clock_i;
	end

	ubs_top u_ubs_top(.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.clock_pin_i(clock_wire), .clock_pin_o(ck_o), .clock_pin_oe_n_o(ck_oe_n),
		.data_pin_i(data_wire), .data_pin_o(dt_o), .data_pin_oe_n_o(dt_oe_n));

	ubs_peer #(.BIT_CLKS(8)) u_ubs_peer(.clock_i(clock_i), .clock_line_i(clock_wire),
		.data_line_i(data_wire), .drv_en_o(drv_en), .drv_val_o(drv_val));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task chk1(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask

	// Waits for pready with no limit of its own; only the watchdog ends a hung access
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock_i);
		penable <= 1'b1;
		do begin
			@(posedge clock_i);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_bit(input int idx, input logic val);
		int n;
		n = 0;
		do begin
			xfer(1'b0, ADDR_STAT, 32'h0);
			n++;
		end while (rd[idx] !== val && n < 400);
		chk1(rd[idx], val);
	endtask

	task close_out;
		if (mismatches == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Whole run needs about a thousand clocks; this leaves ample margin
	initial begin
		#500000;
		mismatches++;
		close_out;
	end

	initial begin
		repeat (3) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		xfer(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, {20'h0, CTRL_RST});
		xfer(1'b0, ADDR_BAUD, 32'h0);
		chk(rd, {16'h0, BAUD_RST});
		xfer(1'b0, ADDR_STAT, 32'h0);
		chk({30'h0, rd[1:0]}, 32'h3);
		xfer(1'b1, 8'h14, 32'h1);
		chk1(er, 1'b1);
		xfer(1'b0, 8'h14, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b1, ADDR_BAUD, 32'h3);
		// Break with dummy byte, then sync byte queued behind it
		xfer(1'b1, ADDR_CTRL, 32'h43);
		fork
			begin
				u_ubs_peer.grab(14, f1);
				u_ubs_peer.grab(10, f2);
			end
			begin
				xfer(1'b1, ADDR_TXD, 32'hFF);
				xfer(1'b0, ADDR_STAT, 32'h0);
				chk1(rd[0], 1'b0);
				wait_bit(1, 1'b1);
				xfer(1'b1, ADDR_TXD, 32'h55);
			end
		join
		chk({18'h0, f1[13:0]}, {18'h0, BREAK_FRAME});
		chk({22'h0, f2[9:0]}, 32'h2AA);
		wait_bit(0, 1'b1);
		xfer(1'b0, ADDR_CTRL, 32'h0);
		chk1(rd[1], 1'b0);
		// Incoming break seen as a zero byte with a bad stop bit
		xfer(1'b1, ADDR_CTRL, 32'h60);
		u_ubs_peer.send(11, 16'h0000);
		repeat (16) @(posedge clock_i);
		xfer(1'b0, ADDR_STAT, 32'h0);
		chk({26'h0, rd[5:0] & 6'h2C}, 32'h2C);
		xfer(1'b0, ADDR_RXD, 32'h0);
		chk(rd, 32'h0);
		xfer(1'b0, ADDR_STAT, 32'h0);
		chk1(rd[4], 1'b1);
		chk1(rd[2], 1'b0);
		// Wake on break with auto-baud armed
		xfer(1'b1, ADDR_CTRL, 32'hC60);
		fork
			u_ubs_peer.send(13, 16'h0000);
			begin
				repeat (30) @(posedge clock_i);
				xfer(1'b0, ADDR_STAT, 32'h0);
				chk1(rd[2], 1'b1);
				xfer(1'b0, ADDR_CTRL, 32'h0);
				chk1(rd[10], 1'b1);
			end
		join
		repeat (8) @(posedge clock_i);
		xfer(1'b0, ADDR_CTRL, 32'h0);
		chk({30'h0, rd[11:10]}, 32'h2);
		xfer(1'b0, ADDR_RXD, 32'h0);
		xfer(1'b0, ADDR_STAT, 32'h0);
		chk1(rd[2], 1'b0);
		u_ubs_peer.send(10, 16'h034A);
		repeat (16) @(posedge clock_i);
		xfer(1'b0, ADDR_STAT, 32'h0);
		chk1(rd[2], 1'b1);
		xfer(1'b0, ADDR_RXD, 32'h0);
		chk(rd, 32'hA5);
		// Synchronous master: two bytes at low idle, one nine-bit char at high idle
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, ADDR_CTRL, k ? 32'h3CD : 32'h4D);
			repeat (4) @(posedge clock_i);
			chk1(ck_o, k[0]);
			u_ubs_peer.pol = k[0];
			u_ubs_peer.sync_cnt = 0;
			u_ubs_peer.sync_bits = 18'h00000;
			u_ubs_peer.sync_on = 1'b1;
			xfer(1'b1, ADDR_TXD, k ? 32'hA6 : 32'h3C);
			repeat (3) @(posedge clock_i);
			chk({30'h0, ck_oe_n, dt_oe_n}, 32'h0);
			if (k == 0) begin
				wait_bit(1, 1'b1);
				xfer(1'b1, ADDR_TXD, 32'hC3);
			end
			wait_bit(0, 1'b1);
			repeat (12) @(posedge clock_i);
			chk(u_ubs_peer.sync_cnt, k ? 32'd9 : 32'd16);
			chk({14'h0, u_ubs_peer.sync_bits}, k ? 32'h1A6 : 32'hC33C);
			chk1(ck_o, k[0]);
			u_ubs_peer.sync_on = 1'b0;
		end
		close_out;
	end
endmodule

`default_nettype wire

// >>> tb/ubs_peer.sv
// Far-side serial node: sends async frames on the data line, samples the
// async transmit line and acts as a clocked slave counting trailing edges.
// Assumes one bit lasts BIT_CLKS system clocks and a pulled-up data line.
`timescale 1ns/1ns
`default_nettype none

module ubs_peer #(
	parameter int BIT_CLKS = 8
) (
	input wire logic clock_i,
	input wire logic clock_line_i,
	input wire logic data_line_i,
	output logic drv_en_o,
	output logic drv_val_o
);
	logic sync_on = 1'b0;
	logic pol = 1'b0;
	int sync_cnt = 0;
	logic [17:0] sync_bits = 18'h00000;

	initial begin
		drv_en_o = 1'b0;
		drv_val_o = 1'b1;
	end

	// A slave samples on the trailing edge, so every extra edge is counted too
	always @(clock_line_i) begin
		if (sync_on && clock_line_i === pol) begin
			if (sync_cnt < 18) begin
				sync_bits[sync_cnt] = data_line_i;
			end
			sync_cnt++;
		end
	end

	// Frames are sent at the rate the port is set to; release leaves the pull-up
	task send(input int n, input logic [15:0] bits);
		for (int i = 0; i < n; i++) begin
			@(posedge clock_i);
			drv_en_o <= 1'b1;
			drv_val_o <= bits[i];
			repeat (BIT_CLKS - 1) @(posedge clock_i);
		end
		@(posedge clock_i);
		drv_en_o <= 1'b0;
	endtask

	// No wait after the last sample, so a frame that follows at once is caught
	task grab(input int n, output logic [15:0] bits);
		bits = 16'hFFFF;
		@(negedge clock_line_i);
		repeat (BIT_CLKS / 2) @(posedge clock_i);
		for (int i = 0; i < n; i++) begin
			if (i > 0) begin
				repeat (BIT_CLKS) @(posedge clock_i);
			end
			bits[i] = clock_line_i;
		end
	endtask
endmodule

`default_nettype wire
